/* File: hdl/qste_core.v */
/*
 Processor-bus slave termination, PCI master parity and posted-write
 error logging for a processor-bus to PCI bridge.
 Assumes one clock, synchronous inputs, bus style strapped at reset and
 FIFO levels, PCI outcomes and access requests supplied by neighbours.
*/
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`include "qste_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module qste_core #(
	parameter FIFO_AW = 9
) (
	input wire clock,
	input wire reset,
	input wire [1:0] style_strap,
	input wire avs_read,
	input wire avs_write,
	input wire [`QSTE_ADDR_W-1:0] avs_address,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire tgt_read_req,
	input wire pci_to_qbus_write_fifo_empty,
	output reg tgt_read_pending_q,
	output wire tgt_read_go,
	input wire qs_req,
	input wire qs_write,
	input wire qs_burst,
	input wire qs_posted,
	input wire qs_image_io,
	input wire [FIFO_AW-1:0] qbus_to_pci_write_fifo_free,
	input wire prefetch_busy,
	input wire qs_burst_active,
	output wire qs_launch,
	input wire pci_done,
	input wire [2:0] pci_outcome,
	input wire pci_xfer_posted,
	input wire [31:0] pci_addr,
	input wire [3:0] pci_cmd,
	input wire [31:0] pci_data,
	input wire [3:0] pci_be,
	input wire [31:0] pci_rd_data,
	output reg [31:0] qs_rd_data_q,
	output reg qbus_read_return_fifo_flush_q,
	output reg post_drop_q,
	output wire slave_suspend,
	input wire addr_phase,
	input wire wr_data_phase,
	input wire rd_data_phase,
	input wire [31:0] ad_in,
	input wire [3:0] cbe_in,
	input wire par_in,
	input wire perr_in_n,
	input wire tgt_addr_par_err,
	input wire tgt_wr_par_err,
	output reg par_out_q,
	output reg par_oe_q,
	output reg perr_out_n_q,
	output reg perr_oe_q,
	output wire size_ack_low_out_n,
	output wire size_ack_high_out_n,
	output wire transfer_ack_out_n,
	output wire bus_error_line_out_n,
	output wire transfer_error_ack_out_n,
	output wire transfer_retry_line_out_n,
	output wire ack_oe,
	output wire err_oe,
	output wire stop_oe,
	output wire qbus_irq,
	output wire pci_irq
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_TERM = 3'b100;

	reg [1:0] style_q;
	reg strap_done_q;
	reg [`QSTE_CTRL_W-1:0] ctrl_q;
	reg dpe_q;
	reg mdp_q;
	reg log_en_q;
	reg unl_q;
	reg err_stat_q;
	reg [3:0] log_cmd_q;
	reg [3:0] log_be_q;
	reg [31:0] log_addr_q;
	reg [31:0] log_data_q;
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [1:0] term_q;
	reg [1:0] term_d;
	reg [2:0] pci_outcome_q;
	reg dly_read_q;
	reg rd_chk_q;
	reg [35:0] rd_sample_q;
	reg ack_read_q;

	function even_par;
		input [35:0] v;
		begin
			even_par = ^v;
		end
	endfunction

	// Style strap is caught in the first cycle after reset release; style A until then
	always @(posedge clock) begin
		if (reset) begin
			strap_done_q <= 1'b0;
			style_q <= `QSTE_STY_A;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			style_q <= style_strap;
		end
	end

	// Register bus: one wait cycle on reads, writes take at once
	wire wr_ctrl = avs_write && avs_address == `QSTE_ADDR_CTRL;
	wire wr_stat = avs_write && avs_address == `QSTE_ADDR_STAT;
	wire wr_elcs = avs_write && avs_address == `QSTE_ADDR_ELCS;
	assign avs_waitrequest = avs_read && !ack_read_q;
	wire perr_en = ctrl_q[`QSTE_C_PAR_RESP];
	wire abed = ctrl_q[`QSTE_C_ABED];
	wire tabe = ctrl_q[`QSTE_C_TABE];

	always @(posedge clock) begin
		if (reset) begin
			ack_read_q <= 1'b0;
			avs_readdata <= `QSTE_ZERO32;
		end else begin
			ack_read_q <= avs_read && !ack_read_q;
			avs_readdata <= `QSTE_ZERO32;
			if (avs_read && !ack_read_q) begin
				case (avs_address)
				`QSTE_ADDR_CTRL: begin
					avs_readdata[`QSTE_CTRL_W-1:0] <= ctrl_q;
				end
				`QSTE_ADDR_STAT: begin
					avs_readdata[`QSTE_S_DPE] <= dpe_q;
					avs_readdata[`QSTE_S_MDP] <= mdp_q;
				end
				`QSTE_ADDR_ELCS: begin
					avs_readdata[`QSTE_E_EN] <= log_en_q;
					avs_readdata[`QSTE_E_UNL] <= unl_q;
					avs_readdata[`QSTE_E_ERRSTAT] <= err_stat_q;
					avs_readdata[`QSTE_E_BE_LO+:4] <= log_be_q;
					avs_readdata[`QSTE_E_CMD_LO+:4] <= log_cmd_q;
				end
				`QSTE_ADDR_EADR: begin
					avs_readdata <= log_addr_q;
				end
				`QSTE_ADDR_EDAT: begin
					avs_readdata <= log_data_q;
				end
				default: begin
					avs_readdata <= `QSTE_ZERO32;
				end
				endcase
			end
		end
	end

	always @(posedge clock) begin
		if (reset) begin
			ctrl_q <= `QSTE_CTRL_RST;
			log_en_q <= 1'b0;
			unl_q <= 1'b0;
		end else begin
			if (wr_ctrl && avs_byteenable[0])
				ctrl_q <= avs_writedata[`QSTE_CTRL_W-1:0];
			if (wr_elcs && avs_byteenable[0]) begin
				log_en_q <= avs_writedata[`QSTE_E_EN];
				unl_q <= avs_writedata[`QSTE_E_UNL];
			end
		end
	end

	// Target read ordering
	always @(posedge clock) begin
		if (reset)
			tgt_read_pending_q <= 1'b0;
		else if (tgt_read_go)
			tgt_read_pending_q <= 1'b0;
		else if (tgt_read_req)
			tgt_read_pending_q <= 1'b1;
	end
	assign tgt_read_go = tgt_read_pending_q && pci_to_qbus_write_fifo_empty;

	// PCI parity generation and check; transfers never halted here
	wire rd_par_err = rd_chk_q && even_par(rd_sample_q) != par_in;
	wire wr_perr = wr_data_phase && !perr_in_n;
	always @(posedge clock) begin
		if (reset) begin
			par_out_q <= 1'b0;
			par_oe_q <= 1'b0;
			perr_out_n_q <= 1'b1;
			perr_oe_q <= 1'b0;
			rd_chk_q <= 1'b0;
			rd_sample_q <= 36'h000000000;
		end else begin
			par_oe_q <= addr_phase || wr_data_phase;
			par_out_q <= even_par({cbe_in, ad_in});
			rd_chk_q <= rd_data_phase;
			rd_sample_q <= {cbe_in, ad_in};
			perr_out_n_q <= !(rd_par_err && perr_en);
			perr_oe_q <= rd_par_err && perr_en;
		end
	end

	wire dpe_set = tgt_addr_par_err || tgt_wr_par_err || rd_par_err;
	wire mdp_set = perr_en && (rd_par_err || wr_perr);
	wire stat_be = wr_stat && avs_byteenable[0];
	always @(posedge clock) begin
		if (reset) begin
			dpe_q <= 1'b0;
			mdp_q <= 1'b0;
		end else begin
			if (dpe_set)
				dpe_q <= 1'b1;
			else if (stat_be && avs_writedata[`QSTE_S_DPE])
				dpe_q <= 1'b0;
			if (mdp_set)
				mdp_q <= 1'b1;
			else if (stat_be && avs_writedata[`QSTE_S_MDP])
				mdp_q <= 1'b0;
		end
	end

	// Slave access decision
	wire suspend = err_stat_q && !unl_q;
	assign slave_suspend = suspend;
	wire [FIFO_AW-1:0] need = qs_burst ? `QSTE_BURST_ENT : `QSTE_SINGLE_ENT;
	wire no_room = qbus_to_pci_write_fifo_free < need;
	wire is_post = qs_write && (qs_posted || qs_burst);
	wire busy = st_q != ST_IDLE || prefetch_busy;
	wire new_req = qs_req && !qs_burst_active && st_q == ST_IDLE;
	assign qs_launch = new_req && !suspend && !busy && !(qs_burst &&
		qs_image_io) && !(is_post && no_room) && !is_post;

	// Translate a delayed outcome
	function [1:0] xlate;
		input [2:0] oc;
		input ma_dis;
		input ta_en;
		begin
			case (oc)
			`QSTE_P_DONE: xlate = `QSTE_T_NORM;
			`QSTE_P_MABT: xlate = ma_dis ? `QSTE_T_NORM : `QSTE_T_BUS_ERROR_LINE;
			`QSTE_P_TABT: xlate = (!ma_dis || ta_en) ? `QSTE_T_BUS_ERROR_LINE :
				`QSTE_T_NORM;
			default: xlate = `QSTE_T_RTRY;
			endcase
		end
	endfunction

	wire dly_done = st_q == ST_WAIT && pci_done && !pci_xfer_posted &&
		pci_outcome != `QSTE_P_RTRY && pci_outcome != `QSTE_P_DISC;
	wire abort = pci_outcome == `QSTE_P_MABT || pci_outcome == `QSTE_P_TABT;

	always @* begin
		st_d = st_q;
		term_d = `QSTE_T_NONE;
		case (st_q)
		ST_IDLE: begin
			if (new_req) begin
				if (qs_burst && qs_image_io)
					term_d = `QSTE_T_BUS_ERROR_LINE;
				else if (suspend || busy || (is_post && no_room))
					term_d = `QSTE_T_RTRY;
				else if (is_post)
					term_d = `QSTE_T_NORM;
				else begin
					term_d = `QSTE_T_RTRY;
					st_d = ST_WAIT;
				end
			end
		end
		ST_WAIT: begin
			if (qs_req)
				term_d = `QSTE_T_RTRY;
			if (dly_done)
				st_d = ST_TERM;
		end
		ST_TERM: begin
			if (qs_req) begin
				term_d = xlate(pci_outcome_q, abed, tabe);
				st_d = ST_IDLE;
			end
		end
		default: begin
			st_d = ST_IDLE;
		end
		endcase
	end

	always @(posedge clock) begin
		if (reset) begin
			st_q <= ST_IDLE;
			term_q <= `QSTE_T_NONE;
			pci_outcome_q <= `QSTE_P_DONE;
			dly_read_q <= 1'b0;
			qs_rd_data_q <= `QSTE_ZERO32;
			qbus_read_return_fifo_flush_q <= 1'b0;
		end else begin
			st_q <= st_d;
			term_q <= term_d;
			qbus_read_return_fifo_flush_q <= 1'b0;
			if (st_q == ST_IDLE && st_d == ST_WAIT)
				dly_read_q <= !qs_write;
			if (dly_done) begin
				pci_outcome_q <= pci_outcome;
				qs_rd_data_q <= abort ? `QSTE_ONES : pci_rd_data;
				qbus_read_return_fifo_flush_q <= abort && dly_read_q;
			end
		end
	end

	// Posted write failures: drop entry, optionally log
	wire post_fail = pci_done && pci_xfer_posted && abort;
	always @(posedge clock) begin
		if (reset) begin
			post_drop_q <= 1'b0;
			err_stat_q <= 1'b0;
			log_cmd_q <= 4'h0;
			log_be_q <= 4'h0;
			log_addr_q <= `QSTE_ZERO32;
			log_data_q <= `QSTE_ZERO32;
		end else begin
			post_drop_q <= post_fail;
			if (post_fail && log_en_q && !err_stat_q) begin
				err_stat_q <= 1'b1;
				log_cmd_q <= pci_cmd;
				log_be_q <= pci_be;
				log_addr_q <= pci_addr;
				log_data_q <= pci_data;
			end else if (wr_elcs && avs_byteenable[0] &&
				avs_writedata[`QSTE_E_ERRSTAT] && !post_fail)
				err_stat_q <= 1'b0;
		end
	end

	// Interrupts
	wire mp_irq = mdp_q && ctrl_q[`QSTE_C_MPIE];
	wire el_irq = err_stat_q && ctrl_q[`QSTE_C_ELIE];
	assign qbus_irq = (mp_irq && !ctrl_q[`QSTE_C_MPDIR]) ||
		(el_irq && !ctrl_q[`QSTE_C_ELDIR]);
	assign pci_irq = (mp_irq && ctrl_q[`QSTE_C_MPDIR]) ||
		(el_irq && ctrl_q[`QSTE_C_ELDIR]);

	// Termination line encoding per bus style
	wire t_n = term_q == `QSTE_T_NORM;
	wire t_b = term_q == `QSTE_T_BUS_ERROR_LINE;
	wire t_r = term_q == `QSTE_T_RTRY;
	wire sa = style_q == `QSTE_STY_A;
	wire sb = style_q == `QSTE_STY_B;
	wire sc = style_q == `QSTE_STY_C;
	wire ack_act = (sa && (t_n || t_b || t_r)) || (sb && t_n) ||
		(sc && (t_n || t_r));
	wire err_act = (sa && (t_b || t_r)) || (sb && t_b) ||
		(sc && (t_b || t_r));
	wire stop_act = (sa && t_r) || (sb && t_r);
	assign ack_oe = ack_act || (sc && t_b);
	assign err_oe = err_act;
	assign stop_oe = stop_act;
	assign size_ack_low_out_n = !ack_act;
	assign size_ack_high_out_n = !ack_act;
	assign transfer_ack_out_n = !ack_act;
	assign bus_error_line_out_n = !err_act;
	assign transfer_error_ack_out_n = !err_act;
	assign transfer_retry_line_out_n = !stop_act;
endmodule
`default_nettype wire

/* File: pkg/qste_regs.vh */
/*
 Register offsets, field positions, reset values and codes for the
 processor-bus slave termination and PCI error-log block.
 Assumes word-aligned Avalon-MM access with 32-bit data.
*/
`ifndef QSTE_REGS_VH
`define QSTE_REGS_VH

// Register byte addresses
`define QSTE_ADDR_CTRL 8'h00
`define QSTE_ADDR_STAT 8'h04
`define QSTE_ADDR_ELCS 8'h08
`define QSTE_ADDR_EADR 8'h0c
`define QSTE_ADDR_EDAT 8'h10
`define QSTE_ADDR_W 8

// Control register fields
`define QSTE_C_PAR_RESP 0
`define QSTE_C_ABED 1
`define QSTE_C_TABE 2
`define QSTE_C_MPIE 3
`define QSTE_C_MPDIR 4
`define QSTE_C_ELIE 5
`define QSTE_C_ELDIR 6
`define QSTE_CTRL_W 7
`define QSTE_CTRL_RST 7'h00

// Status register fields (write one to clear)
`define QSTE_S_DPE 0
`define QSTE_S_MDP 1

// Error log control and status fields
`define QSTE_E_EN 0
`define QSTE_E_UNL 1
`define QSTE_E_ERRSTAT 2
`define QSTE_E_BE_LO 4
`define QSTE_E_CMD_LO 8

// Termination codes
`define QSTE_T_NONE 2'h0
`define QSTE_T_NORM 2'h1
`define QSTE_T_BUS_ERROR_LINE 2'h2
`define QSTE_T_RTRY 2'h3

// PCI outcome codes
`define QSTE_P_DONE 3'h0
`define QSTE_P_MABT 3'h1
`define QSTE_P_TABT 3'h2
`define QSTE_P_RTRY 3'h3
`define QSTE_P_DISC 3'h4

// Bus styles
`define QSTE_STY_A 2'h0
`define QSTE_STY_B 2'h1
`define QSTE_STY_C 2'h2

`define QSTE_ONES 32'hffffffff
`define QSTE_ZERO32 32'h00000000
`define QSTE_BURST_ENT 9'h005
`define QSTE_SINGLE_ENT 9'h002

`endif

/* File: dv/qste_core_asserts.sv */
/* Port checker for qste_core.
 Assumes the style strap stays steady between resets. */
`timescale 1ns/1ps
`default_nettype none
module qste_core_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic [1:0] style_strap,
	input wire logic tgt_read_go,
	input wire logic tgt_read_pending_q,
	input wire logic pci_to_qbus_write_fifo_empty,
	input wire logic addr_phase,
	input wire logic wr_data_phase,
	input wire logic rd_data_phase,
	input wire logic [31:0] ad_in,
	input wire logic [3:0] cbe_in,
	input wire logic par_out_q,
	input wire logic par_oe_q,
	input wire logic perr_out_n_q,
	input wire logic ack_oe,
	input wire logic err_oe,
	input wire logic stop_oe,
	input wire logic qs_launch,
	input wire logic qs_req,
	input wire logic qs_posted
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence s_drive;
		addr_phase || wr_data_phase;
	endsequence
	property p_go;
		tgt_read_pending_q && !pci_to_qbus_write_fifo_empty
			|-> !tgt_read_go ##1 tgt_read_pending_q;
	endproperty
	a_go: assert property (p_go) else $error("read passed early");
	property p_par_oe;
		s_drive |=> par_oe_q;
	endproperty
	a_par_oe: assert property (p_par_oe) else $error("no parity");
	property p_par;
		par_oe_q |-> par_out_q == ^{$past(ad_in), $past(cbe_in)};
	endproperty
	a_par: assert property (p_par) else $error("parity odd");
	property p_perr;
		$fell(perr_out_n_q) |-> $past(rd_data_phase) || $past(rd_data_phase, 2);
	endproperty
	a_perr: assert property (p_perr) else $error("stray perr");
	property p_sty_a;
		style_strap == 2'h0 && (err_oe || stop_oe)
			|-> ack_oe && (err_oe || !stop_oe);
	endproperty
	a_sty_a: assert property (p_sty_a) else $error("bad style a");
	property p_sty_b;
		style_strap == 2'h1 |-> $onehot0({ack_oe, err_oe, stop_oe});
	endproperty
	a_sty_b: assert property (p_sty_b) else $error("bad style b");
	property p_sty_c;
		style_strap == 2'h2 |-> !stop_oe;
	endproperty
	a_sty_c: assert property (p_sty_c) else $error("bad style c");
	property p_launch;
		qs_launch |-> qs_req && !qs_posted;
	endproperty
	a_launch: assert property (p_launch) else $error("bad launch");
endmodule
bind qste_core qste_core_asserts u_chk (
	.clock(clock),
	.reset(reset),
	.style_strap(style_strap),
	.tgt_read_go(tgt_read_go),
	.tgt_read_pending_q(tgt_read_pending_q),
	.pci_to_qbus_write_fifo_empty(pci_to_qbus_write_fifo_empty),
	.addr_phase(addr_phase),
	.wr_data_phase(wr_data_phase),
	.rd_data_phase(rd_data_phase),
	.ad_in(ad_in),
	.cbe_in(cbe_in),
	.par_out_q(par_out_q),
	.par_oe_q(par_oe_q),
	.perr_out_n_q(perr_out_n_q),
	.ack_oe(ack_oe),
	.err_oe(err_oe),
	.stop_oe(stop_oe),
	.qs_launch(qs_launch),
	.qs_req(qs_req),
	.qs_posted(qs_posted)
);
`default_nettype wire

/* File: dv/qste_pci_model.sv */
/* PCI target side model: answers each launched transfer.
 Assumes one launch at a time. */
`include "qste_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module qste_pci_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic launch,
	input wire logic [2:0] final_outcome,
	input wire logic [2:0] lat,
	input wire logic [31:0] rd_word,
	output logic done,
	output logic [2:0] outcome,
	output logic [31:0] rd_data
);
	logic [3:0] cnt_q;
	always @(posedge clock) begin
		done <= 1'b0;
		// Released data lines toggle every cycle instead of holding the last word
		rd_data <= ~rd_data;
		if (reset) begin
			cnt_q <= 4'h0;
			outcome <= 3'h0;
			rd_data <= 32'h0;
		end else if (launch) begin
			cnt_q <= {1'b0, lat} + 4'h4;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q < 4'h4) begin
				done <= 1'b1;
				rd_data <= rd_word;
			end
			// Retry, then disconnect, then the real ending
			case (cnt_q)
				4'h3: outcome <= `QSTE_P_RTRY;
				4'h2: outcome <= `QSTE_P_DISC;
				default: outcome <= final_outcome;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: dv/test_qbus_slave_termination_errlog.sv */
/* Bench for qste_core with a PCI target model.
 Assumes pkg on the include path. */
`include "qste_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_qbus_slave_termination_errlog;
	logic clock = 0, reset = 1, avs_read = 0, avs_write = 0, kick = 0;
	logic tgt_read_req = 0, pci_to_qbus_write_fifo_empty = 0, qs_req = 0;
	logic qs_write = 0, qs_burst = 0, qs_posted = 0, qs_image_io = 0;
	logic prefetch_busy = 0, qs_burst_active = 0, pci_xfer_posted = 0;
	logic addr_phase = 0, wr_data_phase = 0, rd_data_phase = 0, par_in = 0;
	logic perr_in_n = 1, tgt_addr_par_err = 0, tgt_wr_par_err = 0;
	logic [1:0] style_strap = 0;
	logic [2:0] fo = 0, lat = 0, t;
	logic [3:0] avs_byteenable = 4'hf, pci_cmd = 0, pci_be = 0, cbe_in = 0;
	logic [7:0] avs_address = 0;
	logic [8:0] qbus_to_pci_write_fifo_free = 0;
	logic [31:0] avs_writedata = 0, pci_addr = 0, pci_data = 0, ad_in = 0;
	logic [31:0] rw = 0, st = 32'h62, got, ea, ed, el;
	wire pci_done, avs_waitrequest, tgt_read_pending_q, tgt_read_go;
	wire qs_launch, qbus_read_return_fifo_flush_q, post_drop_q, slave_suspend;
	wire par_out_q, par_oe_q, perr_out_n_q, perr_oe_q, ack_oe, err_oe, stop_oe;
	wire size_ack_low_out_n, size_ack_high_out_n, transfer_ack_out_n;
	wire bus_error_line_out_n, transfer_error_ack_out_n, qbus_irq, pci_irq;
	wire transfer_retry_line_out_n;
	wire [2:0] pci_outcome;
	wire [31:0] avs_readdata, qs_rd_data_q, pci_rd_data;
	wire [2:0] seen = {ack_oe && !(size_ack_low_out_n && size_ack_high_out_n
		&& transfer_ack_out_n), err_oe && !(bus_error_line_out_n
		&& transfer_error_ack_out_n), stop_oe && !transfer_retry_line_out_n};
	int errors = 0, num_checks = 0, cyc = 0;
	int drops = 0, flushes = 0, perrs = 0;
	qste_core DUT (.*);
	qste_pci_model PCI (.clock, .reset, .launch(qs_launch | kick),
		.final_outcome(fo), .lat, .rd_word(rw), .done(pci_done),
		.outcome(pci_outcome), .rd_data(pci_rd_data));
	always #10 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		drops += post_drop_q;
		flushes += qbus_read_return_fifo_flush_q;
		perrs += perr_oe_q && !perr_out_n_q;
		if (cyc == 20000) begin
			errors++;
			end_of_test;
		end
	end
	task end_of_test;
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	function logic [31:0] rnd();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction
	function logic [2:0] pat(input logic [1:0] s, te);
		if (te == `QSTE_T_NORM) return 3'b100;
		if (s == `QSTE_STY_B) return te == `QSTE_T_BUS_ERROR_LINE ? 3'b010 : 3'b001;
		if (s == `QSTE_STY_C) return te == `QSTE_T_BUS_ERROR_LINE ? 3'b010 : 3'b110;
		return te == `QSTE_T_BUS_ERROR_LINE ? 3'b110 : 3'b111;
	endfunction
	function logic [1:0] tr(input logic [2:0] o, input logic ab, ta);
		if (o == `QSTE_P_DONE) return `QSTE_T_NORM;
		if (o == `QSTE_P_MABT) return ab ? `QSTE_T_NORM : `QSTE_T_BUS_ERROR_LINE;
		return (!ab || ta) ? `QSTE_T_BUS_ERROR_LINE : `QSTE_T_NORM;
	endfunction
	task rst(input logic [1:0] s);
		reset <= 1;
		style_strap <= s;
		repeat (4) @(posedge clock);
		reset <= 0;
		@(posedge clock);
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic b;
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge clock);
			b = avs_waitrequest;
			got = avs_readdata;
		end while (b);
		avs_read <= 0;
		avs_write <= 0;
	endtask
	// Master access, repeated while retried
	task qacc(input logic w, b, p, i, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			qs_req <= 1;
			qs_write <= w;
			qs_burst <= b;
			qs_posted <= p;
			qs_image_io <= i;
			@(posedge clock);
			qs_req <= 0;
			@(posedge clock);
			t = seen;
			n++;
		end while (t == pat(style_strap, `QSTE_T_RTRY) && n < lim);
	endtask
	task q1(input logic w, b, p, i, input logic [1:0] te, [8:0] fr);
		qbus_to_pci_write_fifo_free <= fr;
		qacc(w, b, p, i, 1);
		check("term", t, pat(style_strap, te));
	endtask
	task dly(input logic w, input logic [2:0] o, input logic ab, ta);
		int f;
		f = flushes;
		fo <= o;
		rw <= rnd();
		lat <= 3'(rnd());
		qacc(w, 0, 0, 0, 40);
		check("dly", t, pat(style_strap, tr(o, ab, ta)));
		if (!w && t == 3'b100)
			check("rdat", qs_rd_data_q, o ? `QSTE_ONES : rw);
		check("flush", flushes - f, 32'(!w && o != 0));
	endtask
	task post(input logic [2:0] o);
		int d;
		d = drops;
		@(posedge clock);
		pci_xfer_posted <= 1;
		fo <= o;
		kick <= 1;
		pci_addr <= rnd();
		pci_data <= rnd();
		pci_cmd <= 4'(rnd());
		pci_be <= 4'(rnd());
		@(posedge clock);
		kick <= 0;
		repeat (14) @(posedge clock);
		check("drop", drops - d, 1);
	endtask
	initial begin
		for (int s = 0; s < 3; s++) begin
			rst(2'(s));
			bus(0, `QSTE_ADDR_CTRL, 0);
			check("ctrl", got, 0);
			q1(1, 0, 1, 0, `QSTE_T_RTRY, 9'h001);
			q1(1, 0, 1, 0, `QSTE_T_NORM, `QSTE_SINGLE_ENT);
			q1(1, 1, 0, 0, `QSTE_T_RTRY, 9'h004);
			q1(1, 1, 0, 1, `QSTE_T_BUS_ERROR_LINE, `QSTE_BURST_ENT);
			dly(0, `QSTE_P_DONE, 0, 0);
			prefetch_busy <= 1;
			q1(0, 0, 0, 0, `QSTE_T_RTRY, 9'h000);
			prefetch_busy <= 0;
			qs_burst_active <= 1;
			qacc(1, 1, 0, 0, 1);
			check("active", t, 3'b000);
			qs_burst_active <= 0;
		end
		for (int k = 0; k < 12; k++) begin
			bus(1, `QSTE_ADDR_CTRL, 32'(k % 4) << 1);
			dly(1'(rnd()), 3'(k / 4), k[0], k[1]);
		end
		for (int e = 0; e < 2; e++) begin
			bus(1, `QSTE_ADDR_CTRL, e ? 32'h19 : 32'h18);
			@(posedge clock);
			rd_data_phase <= 1;
			addr_phase <= 1;
			ad_in <= rnd();
			@(posedge clock);
			rd_data_phase <= 0;
			addr_phase <= 0;
			par_in <= ~^{ad_in, cbe_in};
			repeat (3) @(posedge clock);
			bus(0, `QSTE_ADDR_STAT, 0);
			check("stat", got, 32'(e * 2 + 1));
			check("pirq", pci_irq, 32'(e));
			check("perr", perrs, 32'(e));
			bus(1, `QSTE_ADDR_STAT, 3);
		end
		bus(1, `QSTE_ADDR_CTRL, 32'h1);
		wr_data_phase <= 1;
		perr_in_n <= 0;
		tgt_wr_par_err <= 1;
		@(posedge clock);
		wr_data_phase <= 0;
		perr_in_n <= 1;
		tgt_wr_par_err <= 0;
		bus(0, `QSTE_ADDR_STAT, 0);
		check("wperr", got, 3);
		bus(1, `QSTE_ADDR_STAT, 3);
		tgt_addr_par_err <= 1;
		tgt_read_req <= 1;
		@(posedge clock);
		tgt_addr_par_err <= 0;
		tgt_read_req <= 0;
		@(negedge clock);
		check("go", tgt_read_go, 0);
		check("pend", tgt_read_pending_q, 1);
		@(posedge clock);
		pci_to_qbus_write_fifo_empty <= 1;
		@(negedge clock);
		check("go", tgt_read_go, 1);
		bus(0, `QSTE_ADDR_STAT, 0);
		check("dpe", got, 1);
		bus(1, `QSTE_ADDR_CTRL, 32'h20);
		bus(1, `QSTE_ADDR_ELCS, 32'h3);
		post(`QSTE_P_MABT);
		ea = pci_addr;
		ed = pci_data;
		el = {20'h0, pci_cmd, pci_be, 4'h7};
		post(`QSTE_P_TABT);
		bus(0, `QSTE_ADDR_ELCS, 0);
		check("elcs", got, el);
		bus(0, `QSTE_ADDR_EADR, 0);
		check("eadr", got, ea);
		bus(0, `QSTE_ADDR_EDAT, 0);
		check("edat", got, ed);
		check("qirq", qbus_irq, 1);
		bus(1, `QSTE_ADDR_ELCS, 32'h1);
		@(negedge clock);
		check("susp", slave_suspend, 1);
		bus(1, `QSTE_ADDR_ELCS, 32'h4);
		@(negedge clock);
		check("susp", slave_suspend, 0);
		post(`QSTE_P_MABT);
		bus(0, `QSTE_ADDR_ELCS, 0);
		check("errstat", got[2], 0);
		bus(0, 8'h40, 0);
		check("unmapped", got, 0);
		end_of_test;
	end
endmodule
`default_nettype wire
